// file: hdl/drive_flags_pkg.sv
// =====================================================================
// Shared constants and types
package drive_flags_pkg;

  // Register indices (subindex); byte-free plain port addressing
  localparam logic [7:0] IDX_ENTRY_COUNT  = 8'h00;
  localparam logic [7:0] IDX_LEGACY_POWER = 8'h01;
  localparam logic [7:0] IDX_FIELD_DIR    = 8'h02;
  localparam logic [7:0] IDX_KEEP_GAINS   = 8'h03;
  localparam logic [7:0] IDX_RESTART      = 8'h04;
  localparam logic [7:0] IDX_STATUS       = 8'h05;

  // Values after reset
  localparam logic [7:0] ENTRY_COUNT_VAL  = 8'h03;
  localparam logic [7:0] LEGACY_POWER_RST = 8'h00;
  localparam logic [7:0] FIELD_DIR_RST    = 8'h00;
  localparam logic [7:0] KEEP_GAINS_RST   = 8'h00;

  // Signed encodings of the field direction override
  localparam logic [7:0] FIELD_DEFAULT    = 8'h00;
  localparam logic [7:0] FIELD_POSITIVE   = 8'h01;
  localparam logic [7:0] FIELD_NEGATIVE   = 8'hff;

  // Half duty at the duty width
  localparam logic [7:0] DUTY_HALF        = 8'h80;

  // Status field positions
  localparam int         ST_FIELD_INV_BIT = 0;
  localparam int         ST_STEPPER_BIT   = 1;
  localparam int         ST_PRESET_BIT    = 2;
  localparam int         ST_HOLD_BIT      = 3;

  // Gain selection for auto setup
  typedef enum logic [2:0] {
    GAIN_NONE    = 3'b001,
    GAIN_PRESET  = 3'b010,
    GAIN_USER    = 3'b100
  } gain_src_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// file: hdl/flag_value_check.sv
`timescale 1ns/1ps
// =====================================================================
// Encoding check for flag writes
module flag_value_check (
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic            valid
);

  // Each flag accepts only its listed codes
  always_comb begin
    valid = 1'b0;
    case (addr)
      drive_flags_pkg::IDX_LEGACY_POWER,
      drive_flags_pkg::IDX_KEEP_GAINS: begin
        valid = (wdata == 8'h00) || (wdata == 8'h01);
      end
      drive_flags_pkg::IDX_FIELD_DIR: begin
        valid = (wdata == drive_flags_pkg::FIELD_DEFAULT) || (wdata == drive_flags_pkg::FIELD_POSITIVE) ||
                (wdata == drive_flags_pkg::FIELD_NEGATIVE);
      end
      default: begin
        valid = 1'b0;
      end
    endcase
  end

endmodule

// file: hdl/motor_drive_flag_control.sv
`timescale 1ns/1ps
// Operation
// - Legacy zero, switched on: fixed half duty
// - Legacy one, switched on: controller drives output
// - Field override: 0 default, 1 positive, -1 negative
// - Field override applies only after control restart
// - Keep zero: setup detects motor, loads preset
// - Keep one: setup uses stored user gains
// - Count entry reads three
module motor_drive_flag_control (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire drive_flags_pkg::reg_req_t req,
  output logic [7:0]                     rdata,
  input  wire logic                      switched_on,
  input  wire logic [7:0]                ctrl_duty,
  input  wire logic                      fw_field_inv,
  input  wire logic                      control_restart,
  input  wire logic                      setup_start,
  input  wire logic                      motor_is_stepper,
  output logic [7:0]                     pwm_duty,
  output logic                           hold_torque,
  output logic                           field_inverted,
  output logic                           load_preset,
  output logic                           use_user_gains,
  output logic                           preset_stepper
);

  // =====================================================================
  // Register state
  logic [7:0] legacy_q, legacy_d;
  logic [7:0] field_q, field_d;
  logic [7:0] field_act_q, field_act_d;
  logic [7:0] keep_q, keep_d;
  logic [7:0] rdata_q, rdata_d;
  logic       wr_ok;

  flag_value_check flag_value_check_i (
    .addr  (req.addr),
    .wdata (req.wdata),
    .valid (wr_ok)
  );

  // Writes land only with a listed code; count entry has no storage
  always_comb begin
    legacy_d    = legacy_q;
    field_d     = field_q;
    keep_d      = keep_q;
    field_act_d = field_act_q;
    if (req.wr && wr_ok) begin
      case (req.addr)
        drive_flags_pkg::IDX_LEGACY_POWER: begin
          legacy_d = req.wdata;
        end
        drive_flags_pkg::IDX_FIELD_DIR: begin
          field_d = req.wdata;
        end
        drive_flags_pkg::IDX_KEEP_GAINS: begin
          keep_d = req.wdata;
        end
        default: begin
          legacy_d = legacy_q;
        end
      endcase
    end
    // Rotating field only changes across a restart, never mid-motion
    if (control_restart || (req.wr && req.addr == drive_flags_pkg::IDX_RESTART)) begin
      field_act_d = field_d;
    end
  end

  // Read mux, answer one cycle later; unmapped reads zero
  always_comb begin
    rdata_d = 8'h00;
    if (req.rd) begin
      case (req.addr)
        drive_flags_pkg::IDX_ENTRY_COUNT:  rdata_d = drive_flags_pkg::ENTRY_COUNT_VAL;
        drive_flags_pkg::IDX_LEGACY_POWER: rdata_d = legacy_q;
        drive_flags_pkg::IDX_FIELD_DIR:    rdata_d = field_q;
        drive_flags_pkg::IDX_KEEP_GAINS:   rdata_d = keep_q;
        drive_flags_pkg::IDX_STATUS: begin
          rdata_d[drive_flags_pkg::ST_FIELD_INV_BIT] = field_inverted;
          rdata_d[drive_flags_pkg::ST_STEPPER_BIT]   = preset_stepper;
          rdata_d[drive_flags_pkg::ST_PRESET_BIT]    = load_preset;
          rdata_d[drive_flags_pkg::ST_HOLD_BIT]      = hold_torque;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      legacy_q    <= drive_flags_pkg::LEGACY_POWER_RST;
      field_q     <= drive_flags_pkg::FIELD_DIR_RST;
      field_act_q <= drive_flags_pkg::FIELD_DIR_RST;
      keep_q      <= drive_flags_pkg::KEEP_GAINS_RST;
      rdata_q     <= 8'h00;
    end else begin
      legacy_q    <= legacy_d;
      field_q     <= field_d;
      field_act_q <= field_act_d;
      keep_q      <= keep_d;
      rdata_q     <= rdata_d;
    end
  end
  assign rdata = rdata_q;

  // =====================================================================
  // Output stage
  logic [7:0] duty_q, duty_d;
  logic       hold_q, hold_d;
  logic       finv_q, finv_d;

  // Outside switched-on the controller owns the duty unchanged
  always_comb begin
    duty_d = ctrl_duty;
    hold_d = 1'b1;
    if (switched_on && legacy_q == 8'h00) begin
      duty_d = drive_flags_pkg::DUTY_HALF;
      hold_d = 1'b0;
    end else if (switched_on) begin
      duty_d = ctrl_duty;
      hold_d = 1'b1;
    end
    case (field_act_q)
      drive_flags_pkg::FIELD_POSITIVE: finv_d = 1'b0;
      drive_flags_pkg::FIELD_NEGATIVE: finv_d = 1'b1;
      default:                         finv_d = fw_field_inv;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      duty_q <= drive_flags_pkg::DUTY_HALF;
      hold_q <= 1'b0;
      finv_q <= 1'b0;
    end else begin
      duty_q <= duty_d;
      hold_q <= hold_d;
      finv_q <= finv_d;
    end
  end
  assign pwm_duty       = duty_q;
  assign hold_torque    = hold_q;
  assign field_inverted = finv_q;

  // =====================================================================
  // Auto setup gain source, one-cycle pulses per setup start
  drive_flags_pkg::gain_src_t src_q, src_d;
  logic stp_q, stp_d;

  always_comb begin
    src_d = drive_flags_pkg::GAIN_NONE;
    stp_d = stp_q;
    if (setup_start) begin
      if (keep_q == 8'h01) begin
        src_d = drive_flags_pkg::GAIN_USER;
      end else begin
        src_d = drive_flags_pkg::GAIN_PRESET;
        stp_d = motor_is_stepper;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      src_q <= drive_flags_pkg::GAIN_NONE;
      stp_q <= 1'b0;
    end else begin
      src_q <= src_d;
      stp_q <= stp_d;
    end
  end
  assign load_preset    = src_q[1];
  assign use_user_gains = src_q[2];
  assign preset_stepper = stp_q;

  // =====================================================================
  // Checks
  property p_half_duty;
    @(posedge core_clk) disable iff (rst)
      (switched_on && legacy_q == 8'h00) |=> (pwm_duty == 8'h80 && !hold_torque);
  endproperty
  a_half_duty: assert property (p_half_duty) else $error("half duty not held");

  property p_ctrl_duty;
    @(posedge core_clk) disable iff (rst)
      (switched_on && legacy_q == 8'h01) |=> (pwm_duty == $past(ctrl_duty) && hold_torque);
  endproperty
  a_ctrl_duty: assert property (p_ctrl_duty) else $error("controller duty not passed");

  property p_field_neg;
    @(posedge core_clk) disable iff (rst) (field_act_q == 8'hff) |=> field_inverted;
  endproperty
  a_field_neg: assert property (p_field_neg) else $error("negative field not forced");

  property p_field_pos;
    @(posedge core_clk) disable iff (rst) (field_act_q == 8'h01) |=> !field_inverted;
  endproperty
  a_field_pos: assert property (p_field_pos) else $error("positive field not forced");

  property p_field_hold;
    @(posedge core_clk) disable iff (rst)
      (!control_restart && !(req.wr && req.addr == 8'h04)) |=> $stable(field_act_q);
  endproperty
  a_field_hold: assert property (p_field_hold) else $error("field changed without restart");

  property p_preset;
    @(posedge core_clk) disable iff (rst)
      (setup_start && keep_q == 8'h00) |=> (load_preset && !use_user_gains && preset_stepper == $past(motor_is_stepper));
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");

  property p_user;
    @(posedge core_clk) disable iff (rst) (setup_start && keep_q == 8'h01) |=> (use_user_gains && !load_preset);
  endproperty
  a_user: assert property (p_user) else $error("user gains not used");

  sequence s_count_read;
    req.rd && req.addr == 8'h00;
  endsequence
  property p_count;
    @(posedge core_clk) disable iff (rst) s_count_read |=> (rdata == 8'h03);
  endproperty
  a_count: assert property (p_count) else $error("entry count wrong");

  property p_reject;
    @(posedge core_clk) disable iff (rst)
      (req.wr && req.addr == 8'h01 && req.wdata > 8'h01) |=> $stable(legacy_q);
  endproperty
  a_reject: assert property (p_reject) else $error("invalid code stored");

endmodule

// file: testbench/motor_drive_flag_control_tb_top.sv
`timescale 1ns/1ps
// =====================================================================
// Bench: model with ints, compared at each result
module motor_drive_flag_control_tb_top;
  logic                      core_clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      switched_on = 1'b0, fw_field_inv = 1'b0;
  logic                      control_restart = 1'b0, setup_start = 1'b0;
  logic                      motor_is_stepper = 1'b0;
  logic [7:0]                ctrl_duty = 8'h00;
  drive_flags_pkg::reg_req_t req = '0;
  logic                      hold_torque, field_inverted, load_preset;
  logic                      use_user_gains, preset_stepper;
  logic [7:0]                rdata, pwm_duty, d;
  logic [31:0]               lf = 32'hffb3fc88;
  int                        errors = 0, n_compared = 0, cyc = 0;
  int                        legacy = 0, field = 0, keep = 0, act = 0, pstep = 0;
  logic [7:0]                cand [4] = '{8'h00, 8'h01, 8'hff, 8'h02};

  motor_drive_flag_control motor_drive_flag_control_i (
    .core_clk         (core_clk),
    .rst              (rst),
    .req              (req),
    .rdata            (rdata),
    .switched_on      (switched_on),
    .ctrl_duty        (ctrl_duty),
    .fw_field_inv     (fw_field_inv),
    .control_restart  (control_restart),
    .setup_start      (setup_start),
    .motor_is_stepper (motor_is_stepper),
    .pwm_duty         (pwm_duty),
    .hold_torque      (hold_torque),
    .field_inverted   (field_inverted),
    .load_preset      (load_preset),
    .use_user_gains   (use_user_gains),
    .preset_stepper   (preset_stepper)
  );

  // =====================================================================
  // Clock and hang guard; the run needs well under a thousand cycles
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end

  // =====================================================================
  // Helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req <= '0;
    #1;
    chk(rdata, e);
  endtask

  // Write plus model update; bad codes leave the model alone
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req <= '0;
    case (a)
      8'h01: if (v <= 8'h01) legacy = v;
      8'h02: if (v <= 8'h01 || v == 8'hff) field = v;
      8'h03: if (v <= 8'h01) keep = v;
      8'h04: act = field;
      default: ;
    endcase
  endtask

  task automatic fchk();
    #1;
    chk({7'h0, field_inverted}, {7'h0, act == 0 ? fw_field_inv : act == 255});
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    // Reset values, then a write to the count entry that must not stick
    for (int a = 0; a < 4; a++) begin
      rd_chk(8'(a), a == 0 ? drive_flags_pkg::ENTRY_COUNT_VAL : 8'h00);
    end
    wr(8'h00, 8'h55);
    rd_chk(8'h00, 8'h03);
    $display("test reset_values done");
    // Random and invalid codes into the three flags
    for (int i = 0; i < 24; i++) begin
      lf = nxt(lf);
      d = lf[3] ? lf[15:8] : cand[lf[5:4]];
      wr(8'(1 + i % 3), d);
      rd_chk(8'h01, 8'(legacy));
      rd_chk(8'h02, 8'(field));
      rd_chk(8'h03, 8'(keep));
    end
    $display("test flag_codes done");
    // Output stage in and out of switched-on, both power settings
    for (int i = 0; i < 8; i++) begin
      wr(8'h01, i[2] ? 8'h05 : {7'h0, i[1]});
      lf = nxt(lf);
      switched_on <= i[0];
      ctrl_duty <= lf[7:0];
      repeat (2) @(posedge core_clk);
      #1;
      d = (i[0] && legacy == 0) ? 8'h80 : lf[7:0];
      chk(pwm_duty, d);
      chk({7'h0, hold_torque}, {7'h0, !(i[0] && legacy == 0)});
    end
    $display("test drive_stage done");
    // New override waits for a restart, by pin and by software
    foreach (cand[i]) begin
      wr(8'h02, cand[i]);
      lf = nxt(lf);
      fw_field_inv <= lf[0];
      repeat (2) @(posedge core_clk);
      fchk();
      @(posedge core_clk);
      control_restart <= 1'b1;
      @(posedge core_clk);
      control_restart <= 1'b0;
      act = field;
      repeat (2) @(posedge core_clk);
      fchk();
    end
    wr(8'h02, 8'h01);
    wr(8'h04, 8'h00);
    repeat (2) @(posedge core_clk);
    fchk();
    $display("test field_override done");
    // Auto setup pulses and latched motor type
    for (int i = 0; i < 6; i++) begin
      lf = nxt(lf);
      wr(8'h03, {7'h0, lf[1]});
      @(posedge core_clk);
      setup_start <= 1'b1;
      motor_is_stepper <= lf[0];
      @(posedge core_clk);
      setup_start <= 1'b0;
      #1;
      if (keep == 0) pstep = lf[0];
      chk({7'h0, load_preset}, 8'(keep == 0));
      chk({7'h0, use_user_gains}, 8'(keep == 1));
      @(posedge core_clk);
      #1;
      chk({6'h0, load_preset, use_user_gains}, 8'h00);
      chk({7'h0, preset_stepper}, 8'(pstep));
    end
    // Status word gathers the live outputs; the setup pulse has passed by now
    d = 8'((int'(act == 0 ? fw_field_inv : act == 255) << drive_flags_pkg::ST_FIELD_INV_BIT) |
           (pstep << drive_flags_pkg::ST_STEPPER_BIT) |
           (int'(!(switched_on && legacy == 0)) << drive_flags_pkg::ST_HOLD_BIT));
    rd_chk(drive_flags_pkg::IDX_STATUS, d);
    $display("test auto_setup done");
    close_out();
  end
endmodule
